// ### design/bdmc_top.sv
// Purpose: mode controller for a broadcast audio delay line
// Assumes: one sample strobe per sample period; delay memory is external, addressed by pointers
// Notes: the fifo holds incoming studio samples until a sample period is processed
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module bdmc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bypass_btn,
   input wire logic build_btn,
   input wire logic dump_btn,
   input wire logic in_valid,
   output logic in_ready,
   input wire bdmc_pkg::bdmc_audio_t in_audio,
   input wire logic stream_ok,
   input wire bdmc_pkg::bdmc_audio_t dly_rd_audio,
   input wire bdmc_pkg::bdmc_audio_t file_audio,
   input wire logic file_done,
   output logic file_play,
   output logic mem_wr,
   output bdmc_pkg::bdmc_audio_t mem_wr_audio,
   output logic mem_clear,
   output logic [bdmc_pkg::DLY_W-1:0] dly_depth,
   output logic out_valid,
   output bdmc_pkg::bdmc_audio_t out_audio,
   output logic bypass_relay,
   output logic transport_lamps,
   output bdmc_pkg::bdmc_meter_t meter
);
   typedef struct packed {
      bdmc_pkg::bdmc_state_t st;
      bdmc_pkg::bdmc_mode_t mode;
      logic [3:0] speed;
      logic [bdmc_pkg::DLY_W-1:0] target;
      logic [bdmc_pkg::DLY_W-1:0] file_len;
      logic [bdmc_pkg::DLY_W-1:0] depth;
      logic [15:0] slew_cnt;
      logic net_in;
      logic int_err;
      logic mem_wr;
      bdmc_pkg::bdmc_audio_t wr_audio;
      logic mem_clear;
      logic file_play;
      logic out_valid;
      bdmc_pkg::bdmc_audio_t out_audio;
      bdmc_pkg::bdmc_meter_t meter;
      logic [31:0] prdata;
   } bdmc_state_rec_t;

   bdmc_state_rec_t s_q, s_d;
   logic fifo_valid;
   logic fifo_pop;
   bdmc_pkg::bdmc_audio_t fifo_audio;
   logic wr_acc;
   logic bypass_req;
   logic build_req;
   logic dump_req;
   logic [15:0] slew_limit;

   function automatic logic [2:0] bdmc_mtr_level(input logic [bdmc_pkg::SAMPLE_W-1:0] smp);
      logic [bdmc_pkg::SAMPLE_W-1:0] mag;
      mag = smp[bdmc_pkg::SAMPLE_W-1] ? bdmc_pkg::SAMPLE_W'(~smp + 1'b1) : smp;
      if (mag >= bdmc_pkg::MTR_T3) bdmc_mtr_level = 3'd4;
      else if (mag >= bdmc_pkg::MTR_T2) bdmc_mtr_level = 3'd3;
      else if (mag >= bdmc_pkg::MTR_T1) bdmc_mtr_level = 3'd2;
      else if (mag >= bdmc_pkg::MTR_T0) bdmc_mtr_level = 3'd1;
      else bdmc_mtr_level = 3'd0;
   endfunction

   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
      reg_hit = (a == ofs);
   endfunction

   bdmc_fifo #(
      .WIDTH($bits(bdmc_pkg::bdmc_audio_t)),
      .DEPTH(bdmc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .flush(bypass_req),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .in_data(in_audio),
      .out_valid(fifo_valid),
      .out_ready(1'b1),
      .out_data(fifo_audio)
   );

   assign fifo_pop = fifo_valid;
   assign wr_acc = psel && penable && pwrite;
   assign bypass_req = bypass_btn || (wr_acc && reg_hit(paddr, bdmc_pkg::CTRL_OFS) &&
                       pwdata[bdmc_pkg::CTRL_BYPASS_BIT]);
   assign build_req = build_btn || (wr_acc && reg_hit(paddr, bdmc_pkg::CTRL_OFS) &&
                      pwdata[bdmc_pkg::CTRL_BUILD_BIT]);
   assign dump_req = dump_btn || (wr_acc && reg_hit(paddr, bdmc_pkg::CTRL_OFS) &&
                     pwdata[bdmc_pkg::CTRL_DUMP_BIT]);
   assign slew_limit = bdmc_pkg::SLEW_BASE >> s_q.speed;

   always_comb begin
      logic [2:0] lvl;
      logic [2:0] lvl_r;
      logic step;
      s_d = s_q;
      lvl = bdmc_mtr_level(fifo_audio.left);
      lvl_r = bdmc_mtr_level(fifo_audio.right);
      step = 1'b0;
      s_d.mem_wr = 1'b0;
      s_d.mem_clear = 1'b0;
      s_d.out_valid = 1'b0;
      // register writes
      if (wr_acc) begin
         if (reg_hit(paddr, bdmc_pkg::CTRL_OFS)) begin
            s_d.mode = bdmc_pkg::bdmc_mode_t'(pwdata[bdmc_pkg::CTRL_MODE_LSB +: 2]);
            s_d.speed = pwdata[bdmc_pkg::CTRL_SPEED_LSB +: 4];
            s_d.net_in = pwdata[bdmc_pkg::CTRL_NETIN_BIT];
            s_d.int_err = pwdata[bdmc_pkg::CTRL_ERROR_BIT];
         end
         if (reg_hit(paddr, bdmc_pkg::TARGET_OFS)) s_d.target = pwdata[bdmc_pkg::DLY_W-1:0];
         if (reg_hit(paddr, bdmc_pkg::FILE_OFS)) s_d.file_len = pwdata[bdmc_pkg::DLY_W-1:0];
      end
      // register reads
      s_d.prdata = 32'h00000000;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            bdmc_pkg::CTRL_OFS: s_d.prdata = {14'h0000, s_q.int_err, s_q.net_in, 4'h0, s_q.speed,
                                              2'b00, s_q.mode, 4'h0};
            bdmc_pkg::TARGET_OFS: s_d.prdata = {12'h000, s_q.target};
            bdmc_pkg::FILE_OFS: s_d.prdata = {12'h000, s_q.file_len};
            bdmc_pkg::STATUS_OFS: s_d.prdata = {22'h000000, s_q.meter.warn, s_q.meter.lit,
                                                2'b00, s_q.st};
            bdmc_pkg::DELAY_OFS: s_d.prdata = {12'h000, s_q.depth};
            default: s_d.prdata = 32'h00000000;
         endcase
      end
      // meter from instantaneous peak of the louder channel
      if (fifo_pop) begin
         if (lvl_r > lvl) lvl = lvl_r;
         s_d.meter.lit = (4'hf << (3'd4 - lvl)) & 4'hf;
         s_d.meter.lit = {s_d.meter.lit[0], s_d.meter.lit[1], s_d.meter.lit[2], s_d.meter.lit[3]};
      end
      s_d.meter.warn = (s_q.net_in && !stream_ok) || s_q.int_err;
      if (s_d.meter.warn) s_d.meter.lit = 4'hf;
      // per-sample processing
      if (fifo_pop) begin
         s_d.out_valid = 1'b1;
         s_d.wr_audio = fifo_audio;
         s_d.slew_cnt = (s_q.slew_cnt >= slew_limit) ? 16'h0000 : 16'(s_q.slew_cnt + 1'b1);
         step = (s_q.slew_cnt >= slew_limit);
         case (s_q.st)
            bdmc_pkg::BDMC_ST_BYPASS: begin
               s_d.out_audio = fifo_audio;
            end
            bdmc_pkg::BDMC_ST_READY: begin
               s_d.out_audio = fifo_audio;
            end
            bdmc_pkg::BDMC_ST_EXPAND: begin
               s_d.mem_wr = 1'b1;
               s_d.out_audio = dly_rd_audio;
               if (step) s_d.depth = bdmc_pkg::DLY_W'(s_q.depth + 1'b1);
               if (s_d.depth >= s_q.target) s_d.st = bdmc_pkg::BDMC_ST_DELAYED;
            end
            bdmc_pkg::BDMC_ST_INSERT: begin
               s_d.mem_wr = 1'b1;
               s_d.out_audio = file_audio;
               s_d.depth = bdmc_pkg::DLY_W'(s_q.depth + 1'b1);
            end
            bdmc_pkg::BDMC_ST_FILL: begin
               s_d.mem_wr = 1'b1;
               s_d.out_audio = '0;
               s_d.depth = bdmc_pkg::DLY_W'(s_q.depth + 1'b1);
               if (s_d.depth >= s_q.target) s_d.st = bdmc_pkg::BDMC_ST_DELAYED;
            end
            bdmc_pkg::BDMC_ST_DELAYED: begin
               s_d.mem_wr = 1'b1;
               s_d.out_audio = dly_rd_audio;
               // slew toward target after a mismatched insert
               if (step && s_q.depth < s_q.target) s_d.depth = bdmc_pkg::DLY_W'(s_q.depth + 1'b1);
               if (step && s_q.depth > s_q.target) s_d.depth = bdmc_pkg::DLY_W'(s_q.depth - 1'b1);
            end
            default: s_d.st = bdmc_pkg::BDMC_ST_BYPASS;
         endcase
      end
      // insert file end joins delayed audio, at normal rate if lengths match
      if (s_q.st == bdmc_pkg::BDMC_ST_INSERT && file_done) begin
         s_d.st = bdmc_pkg::BDMC_ST_DELAYED;
         s_d.file_play = 1'b0;
      end
      // dump drops back by the full depth stored, then rebuilds
      if (dump_req && s_q.st == bdmc_pkg::BDMC_ST_DELAYED) begin
         s_d.depth = '0;
         s_d.st = bdmc_pkg::BDMC_ST_EXPAND;
      end
      // build starts the selected method
      if (build_req && s_q.st == bdmc_pkg::BDMC_ST_READY) begin
         case (s_q.mode)
            bdmc_pkg::BDMC_MODE_INSERT: begin
               s_d.st = bdmc_pkg::BDMC_ST_INSERT;
               s_d.file_play = 1'b1;
            end
            bdmc_pkg::BDMC_MODE_FILL: s_d.st = bdmc_pkg::BDMC_ST_FILL;
            default: s_d.st = bdmc_pkg::BDMC_ST_EXPAND;
         endcase
      end
      // bypass toggles: entering clears memory, leaving starts at zero delay
      if (bypass_req) begin
         if (s_q.st == bdmc_pkg::BDMC_ST_BYPASS) begin
            s_d.st = bdmc_pkg::BDMC_ST_READY;
         end else begin
            s_d.st = bdmc_pkg::BDMC_ST_BYPASS;
         end
         s_d.depth = '0;
         s_d.mem_clear = 1'b1;
         s_d.mem_wr = 1'b0;
         s_d.file_play = 1'b0;
         s_d.slew_cnt = 16'h0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.st <= bdmc_pkg::BDMC_ST_BYPASS;
         s_q.speed <= bdmc_pkg::SPEED_RST;
         s_q.target <= bdmc_pkg::TARGET_RST;
         s_q.file_len <= bdmc_pkg::FILE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign file_play = s_q.file_play;
   assign mem_wr = s_q.mem_wr;
   assign mem_wr_audio = s_q.wr_audio;
   assign mem_clear = s_q.mem_clear;
   assign dly_depth = s_q.depth;
   assign out_valid = s_q.out_valid;
   // bypass path is combinational so the switch is immediate
   assign out_audio = (s_q.st == bdmc_pkg::BDMC_ST_BYPASS) ? in_audio : s_q.out_audio;
   assign bypass_relay = (s_q.st == bdmc_pkg::BDMC_ST_BYPASS);
   assign transport_lamps = (s_q.st == bdmc_pkg::BDMC_ST_BYPASS);
   assign meter = s_q.meter;
endmodule // bdmc_top

// ### design/bdmc_pkg.sv
// Purpose: shared constants and types for the broadcast delay mode controller
// Assumes: 16-bit audio samples, one sample strobe per sample period
// Notes: register offsets are byte addresses on the apb bus
//
// What this block does
// - bypass request routes input to output at once and clears delay memory
// - during bypass analog and digital inputs pass straight through, no delay
// - build method is a register field that may change at any time
// - insert mode: build plays stored file while studio audio is written to memory
// - at insert file end output switches to delayed audio; dump then honoured
// - file length equal to target: join delayed audio at normal rate
// - file length differs: join at file end, then slew rate toward target
// - early start fill: count up delay, store audio, keep output muted
// - early start fill: at full target, unmute and send delayed audio
// - higher speed setting gives larger rate deviation, faster expand or drain; early start fill steps every sample at any speed
// - all four meter lamps off below the lowest threshold
// - more lamps light as peak level rises toward full scale
// - all lamps show warning when network input is selected and its stream is missing, or on internal error
// - meter follows instantaneous sample peaks, not averaged level
// - after power up the block is in bypass with transport lamps lit
// - leaving bypass into ready starts with zero accumulated delay
package bdmc_pkg;
   localparam int SAMPLE_W = 16;
   localparam int DLY_W = 20;
   localparam int FIFO_DEPTH = 4;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] TARGET_OFS = 8'h04;
   localparam logic [7:0] FILE_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] DELAY_OFS = 8'h10;
   // control fields
   localparam int CTRL_BYPASS_BIT = 0;
   localparam int CTRL_BUILD_BIT = 1;
   localparam int CTRL_DUMP_BIT = 2;
   localparam int CTRL_MODE_LSB = 4;
   localparam int CTRL_SPEED_LSB = 8;
   localparam int CTRL_NETIN_BIT = 16;
   localparam int CTRL_ERROR_BIT = 17;
   // reset values
   localparam logic [DLY_W-1:0] TARGET_RST = 20'h00000;
   localparam logic [DLY_W-1:0] FILE_RST = 20'h00000;
   localparam logic [3:0] SPEED_RST = 4'h7;
   // meter thresholds on sample magnitude, lowest is -36 dbfs
   localparam logic [SAMPLE_W-1:0] MTR_T0 = 16'h0207;
   localparam logic [SAMPLE_W-1:0] MTR_T1 = 16'h0818;
   localparam logic [SAMPLE_W-1:0] MTR_T2 = 16'h2026;
   localparam logic [SAMPLE_W-1:0] MTR_T3 = 16'h5a9d;
   // rate slew: samples between extra fill/drain steps at speed s is SLEW_BASE >> s
   localparam logic [15:0] SLEW_BASE = 16'h8000;

   typedef enum logic [1:0] {
      BDMC_MODE_EXPAND = 2'b00,
      BDMC_MODE_INSERT = 2'b01,
      BDMC_MODE_FILL = 2'b10
   } bdmc_mode_t;

   typedef enum logic [2:0] {
      BDMC_ST_BYPASS = 3'b000,
      BDMC_ST_READY = 3'b001,
      BDMC_ST_EXPAND = 3'b010,
      BDMC_ST_INSERT = 3'b011,
      BDMC_ST_FILL = 3'b100,
      BDMC_ST_DELAYED = 3'b101
   } bdmc_state_t;

   typedef enum logic [1:0] {
      BDMC_SRC_LIVE = 2'b00,
      BDMC_SRC_DELAYED = 2'b01,
      BDMC_SRC_FILE = 2'b10,
      BDMC_SRC_MUTE = 2'b11
   } bdmc_src_t;

   typedef struct packed {
      logic [SAMPLE_W-1:0] left;
      logic [SAMPLE_W-1:0] right;
   } bdmc_audio_t;

   typedef struct packed {
      logic [3:0] lit;
      logic warn;
   } bdmc_meter_t;
endpackage

// ### design/bdmc_fifo.sv
// Purpose: small valid/ready fifo for audio words
// Assumes: single clock
// Notes: full and empty follow the occupancy count
`timescale 1ns/100ps
module bdmc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } bdmc_fifo_st_t;
   bdmc_fifo_st_t st_q, st_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic push, pop;

   assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_q.cnt != '0);
   assign out_data = mem_q[st_q.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_d = st_q;
      if (push) st_d.wp = AW'(st_q.wp + 1'b1);
      if (pop) st_d.rp = AW'(st_q.rp + 1'b1);
      st_d.cnt = (AW+1)'(st_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      if (flush) st_d = '0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge pclk) begin
      if (push) mem_q[st_q.wp] <= in_data;
   end
endmodule // bdmc_fifo

// ### verif/bdmc_far.sv
// Purpose: far side model, delay memory and insert file store
// Assumes: one insert sample used per out_valid
// Notes: file data toggles while playback is off
`timescale 1ns/100ps
module bdmc_far #(
   parameter int FILE_LEN = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mem_wr,
   input wire logic mem_clear,
   input wire bdmc_pkg::bdmc_audio_t mem_wr_audio,
   input wire logic [19:0] dly_depth,
   input wire logic file_play,
   input wire logic out_valid,
   output bdmc_pkg::bdmc_audio_t dly_rd_audio,
   output bdmc_pkg::bdmc_audio_t file_audio,
   output logic file_done
);
   bdmc_pkg::bdmc_audio_t mem [64];
   logic [5:0] wp;
   logic [15:0] cnt;
   logic tog;
   assign dly_rd_audio = mem[wp - dly_depth[5:0]];
   assign file_audio = file_play ? {16'hf11e, cnt} : {16'h0bad, {16{tog}}};
   assign file_done = file_play && (cnt >= 16'(FILE_LEN));
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp <= 6'h0;
         cnt <= 16'h0;
         tog <= 1'b0;
      end else begin
         tog <= !tog;
         if (mem_clear) wp <= 6'h0;
         else if (mem_wr) begin
            mem[wp] <= mem_wr_audio;
            wp <= wp + 6'h1;
         end
         if (!file_play) cnt <= 16'h0;
         else if (out_valid) cnt <= cnt + 16'h1;
      end
   end
endmodule // bdmc_far

// ### verif/bdmc_top_props.sv
// Purpose: port-level checks of the delay mode controller
// Assumes: single clock domain
// Notes: bound to every bdmc_top
`timescale 1ns/100ps
module bdmc_top_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic bypass_btn,
   input wire bdmc_pkg::bdmc_audio_t in_audio,
   input wire logic file_done,
   input wire logic file_play,
   input wire logic mem_wr,
   input wire logic mem_clear,
   input wire logic [bdmc_pkg::DLY_W-1:0] dly_depth,
   input wire bdmc_pkg::bdmc_audio_t out_audio,
   input wire logic bypass_relay,
   input wire logic transport_lamps
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_boot; $rose(presetn) |-> bypass_relay && transport_lamps; endproperty
   a_boot: assert property (p_boot) else $error("not in bypass after reset");
   property p_enter; bypass_btn && !bypass_relay |-> ##[1:3] bypass_relay; endproperty
   a_enter: assert property (p_enter) else $error("bypass not entered");
   property p_clear; bypass_btn && !bypass_relay |-> ##[1:3] mem_clear; endproperty
   a_clear: assert property (p_clear) else $error("memory not cleared on bypass");
   property p_clr_depth; mem_clear |-> ##[0:2] dly_depth == 0; endproperty
   a_clr_depth: assert property (p_clr_depth) else $error("depth kept after clear");
   property p_pass; bypass_relay |-> out_audio == in_audio; endproperty
   a_pass: assert property (p_pass) else $error("bypass output differs from input");
   property p_nowr; bypass_relay && $past(bypass_relay, 3) |-> !mem_wr; endproperty
   a_nowr: assert property (p_nowr) else $error("memory written in bypass");
   property p_leave; $fell(bypass_relay) |-> dly_depth == 0; endproperty
   a_leave: assert property (p_leave) else $error("ready entered with delay");
   property p_done; file_play && file_done |-> ##[1:3] !file_play; endproperty
   a_done: assert property (p_done) else $error("playback not stopped at file end");
   property p_step;
      !$stable(dly_depth) |-> dly_depth == 0 || dly_depth == $past(dly_depth) + 1 ||
         dly_depth + 1 == $past(dly_depth);
   endproperty
   a_step: assert property (p_step) else $error("depth jumped");
   property p_apb; psel |-> pready && !pslverr; endproperty
   a_apb: assert property (p_apb) else $error("bus answer wrong");
endmodule // bdmc_top_props
bind bdmc_top bdmc_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .pready(pready),
   .pslverr(pslverr), .bypass_btn(bypass_btn), .in_audio(in_audio), .file_done(file_done),
   .file_play(file_play), .mem_wr(mem_wr), .mem_clear(mem_clear), .dly_depth(dly_depth),
   .out_audio(out_audio), .bypass_relay(bypass_relay), .transport_lamps(transport_lamps));

// ### verif/bdmc_top_tb.sv
// Purpose: self-checking bench of the delay mode controller
// Assumes: far side model supplies memory and insert file
// Notes: scenarios run back to back
`timescale 1ns/100ps
module bdmc_top_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, in_valid, in_ready, stream_ok;
   logic bypass_btn, build_btn, dump_btn, file_done, file_play, mem_wr, mem_clear, out_valid;
   logic bypass_relay, transport_lamps;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [19:0] dly_depth;
   bdmc_pkg::bdmc_audio_t in_audio, dly_rd_audio, file_audio, mem_wr_audio, out_audio, got, fa;
   bdmc_pkg::bdmc_meter_t meter;
   int errors, total_checks;
   bdmc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .bypass_btn, .build_btn, .dump_btn, .in_valid, .in_ready, .in_audio, .stream_ok, .dly_rd_audio,
      .file_audio, .file_done, .file_play, .mem_wr, .mem_wr_audio, .mem_clear, .dly_depth, .out_valid,
      .out_audio, .bypass_relay, .transport_lamps, .meter);
   bdmc_far #(.FILE_LEN(4)) far (.pclk, .presetn, .mem_wr, .mem_clear, .mem_wr_audio, .dly_depth,
      .file_play, .out_valid, .dly_rd_audio, .file_audio, .file_done);
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic wrap_up;
      $display("errors=%0d checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bound(input int n);
      if (n >= 50) begin
         errors++;
         wrap_up();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 50);
      q = prdata;
      bound(n);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic put(input bdmc_pkg::bdmc_audio_t s);
      int n;
      in_audio <= s;
      in_valid <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (!in_ready && n < 50);
      bound(n);
      @(posedge pclk);
      in_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (!out_valid && n < 50);
      bound(n);
      got = out_audio;
      fa = file_audio;
      @(posedge pclk);
   endtask
   task automatic press(input logic [2:0] k);
      {dump_btn, build_btn, bypass_btn} <= k;
      @(posedge pclk);
      {dump_btn, build_btn, bypass_btn} <= 3'b000;
      repeat (3) @(posedge pclk);
   endtask
   task automatic s_boot;
      @(posedge pclk);
      chk(bypass_relay & transport_lamps, 1);
      apb(0, bdmc_pkg::STATUS_OFS, 0);
      chk(q[2:0], 0);
      apb(0, bdmc_pkg::CTRL_OFS, 0);
      chk(q[11:8], 4'h7);
      apb(0, 8'h3c, 0);
      chk(q, 0);
      in_audio <= 32'h1234_8765;
      @(negedge pclk);
      chk(out_audio, 32'h1234_8765);
      @(posedge pclk);
   endtask
   task automatic go_ready;
      press(3'b001);
      apb(0, bdmc_pkg::STATUS_OFS, 0);
      chk(q[2:0], 1);
      apb(0, bdmc_pkg::DELAY_OFS, 0);
      chk(q, 0);
   endtask
   task automatic s_crash;
      press(3'b001);
      chk(bypass_relay, 1);
      apb(0, bdmc_pkg::DELAY_OFS, 0);
      chk(q, 0);
   endtask
   task automatic s_fill;
      go_ready();
      apb(1, bdmc_pkg::TARGET_OFS, 32'h4);
      apb(1, bdmc_pkg::CTRL_OFS, 32'h0f20);
      press(3'b010);
      for (int i = 1; i <= 4; i++) begin
         put({16'(i), 16'h00aa});
         if (i < 4) chk(got, 0);
      end
      apb(0, bdmc_pkg::STATUS_OFS, 0);
      chk(q[2:0], 5);
      put(32'h0005_00aa);
      chk(got, 32'h0001_00aa);
      press(3'b100);
      apb(0, bdmc_pkg::DELAY_OFS, 0);
      chk(q, 0);
   endtask
   task automatic s_insert(input logic [19:0] tgt);
      go_ready();
      apb(1, bdmc_pkg::FILE_OFS, 32'h4);
      apb(1, bdmc_pkg::TARGET_OFS, 32'(tgt));
      apb(1, bdmc_pkg::CTRL_OFS, 32'h0f10);
      press(3'b010);
      chk(file_play, 1);
      for (int i = 0; i < 4; i++) begin
         put({16'h0, 16'(i)});
         chk(got, fa);
      end
      repeat (3) @(posedge pclk);
      chk(file_play, 0);
      repeat (8) put(32'h0);
      apb(0, bdmc_pkg::DELAY_OFS, 0);
      chk(q, 32'(tgt));
      s_crash();
   endtask
   task automatic s_speed;
      logic [19:0] dep [2];
      for (int i = 0; i < 2; i++) begin
         go_ready();
         apb(1, bdmc_pkg::TARGET_OFS, 32'hff);
         apb(1, bdmc_pkg::CTRL_OFS, i ? 32'h0e00 : 32'h0f00);
         press(3'b010);
         repeat (6) put(32'h0);
         dep[i] = dly_depth;
         press(3'b001);
      end
      chk(dep[0] > dep[1], 1);
   endtask
   task automatic s_meter;
      logic [31:0] smp [6] = '{32'h0100_0000, 32'h0000_0300, 32'h0900_0000, 32'h3000_0000, 32'h0000_9000, 0};
      logic [3:0] lit [6] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf, 4'h0};
      logic [3:0] so = 4'b0110;
      logic [3:0] ex = 4'b0101;
      logic [17:0] cw [4] = '{18'h10000, 18'h10000, 18'h20000, 18'h0};
      go_ready();
      for (int i = 0; i < 6; i++) begin
         put(smp[i]);
         repeat (2) @(posedge pclk);
         chk(meter.lit, lit[i]);
      end
      for (int i = 0; i < 4; i++) begin
         stream_ok <= so[i];
         apb(1, bdmc_pkg::CTRL_OFS, 32'(cw[i]));
         repeat (3) @(posedge pclk);
         chk(meter.warn, ex[i]);
         if (ex[i]) chk(meter.lit, 4'hf);
      end
   endtask
   initial begin
      {psel, penable, pwrite, bypass_btn, build_btn, dump_btn, in_valid} = '0;
      paddr = 8'h0;
      pwdata = 32'h0;
      in_audio = 32'h0;
      stream_ok = 1'b1;
      presetn = 1'b0;
      errors = 0;
      total_checks = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      s_boot();
      s_fill();
      s_crash();
      s_insert(20'h4);
      s_insert(20'h6);
      s_speed();
      s_meter();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      wrap_up();
   end
endmodule // bdmc_top_tb
